// ### verilog/iscl_pkg.sv
// Constants, types and helpers for the inactivity sleep controller
package iscl_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned SEC_CYC_DEF = CLK_HZ * TICK_S;
  localparam int unsigned PRE_W = 25;
  // Settings limits and reset values
  localparam logic [11:0] MIN_TOUT_S = 12'h00A;
  localparam logic [11:0] MAX_TOUT_S = 12'hE4C;
  localparam logic [6:0] MAX_FIELD = 7'h3C;
  localparam logic [6:0] DEF_MIN = 7'h01;
  localparam logic [6:0] DEF_SEC = 7'h00;
  localparam logic DEF_EN = 1'b0;
  // Register offsets and field positions
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TOUT_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] IDLE_OFS = 8'h0C;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_SAVE_BIT = 1;
  localparam int unsigned TOUT_SEC_LSB = 8;
  localparam int unsigned STAT_SLEEP_BIT = 0;
  localparam int unsigned STAT_SAVED_BIT = 1;
  localparam int unsigned STAT_ERR_BIT = 2;
  // Command characters
  localparam logic [7:0] CH_OPEN = 8'h7B;
  localparam logic [7:0] CH_CLOSE = 8'h7D;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_M = 8'h4D;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_W = 8'h57;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_K = 8'h4B;
  // Label codes; digit labels reuse the digit characters
  localparam logic [7:0] MINUTE_LABEL_CODE = 8'hB0;
  localparam logic [7:0] SECOND_LABEL_CODE = 8'hB1;

  typedef enum logic [1:0] {
    K_EN = 2'b00,
    K_TOUT = 2'b01,
    K_SAVE = 2'b10
  } iscl_kind_e;

  function automatic logic is_digit(logic [7:0] b);
    return (b >= CH_0) && (b <= CH_9);
  endfunction : is_digit

  function automatic logic [11:0] tout_s(logic [6:0] m, logic [6:0] s);
    return 12'(12'(m) * 12'h03C + 12'(s));
  endfunction : tout_s

  function automatic logic tout_ok(logic [6:0] m, logic [6:0] s);
    return (m <= MAX_FIELD) && (s <= MAX_FIELD) &&
           (tout_s(m, s) >= MIN_TOUT_S);
  endfunction : tout_ok

  function automatic logic [7:0] hdr_char(logic [2:0] i, logic sv);
    case (i)
      3'h0: return CH_M;
      3'h1: return CH_C;
      3'h2: return sv ? CH_M : CH_1;
      3'h3: return sv ? CH_D : CH_1;
      3'h4: return CH_W;
      default: return CH_T;
    endcase
  endfunction : hdr_char

  function automatic logic [7:0] dec_tens(logic [6:0] v);
    return CH_0 + 8'(v / 7'h0A);
  endfunction : dec_tens

  function automatic logic [7:0] dec_ones(logic [6:0] v);
    return CH_0 + 8'(v % 7'h0A);
  endfunction : dec_ones
endpackage : iscl_pkg

// ### verilog/iscl_cmd_parser.sv
// Framed host command parser for the inactivity sleep controller
`timescale 1ns/1ps
module iscl_cmd_parser
  import iscl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic cmd_valid,
  output iscl_kind_e cmd_kind,
  output logic [6:0] cmd_a,
  output logic [6:0] cmd_b
);
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_HDR = 2'b01,
    P_ARG = 2'b11
  } iscl_pst_e;

  iscl_pst_e st_q;
  logic [2:0] idx_q;
  logic save_q;
  logic err_q;
  logic [1:0] fld_q;
  logic [6:0] acc_q [3];
  logic [1:0] nd_q [3];
  logic sv;
  logic en_form;
  logic to_form;
  logic done;

  assign sv = (idx_q == 3'h2) ? (rx_data == CH_M) : save_q;
  assign en_form = (fld_q == 2'h0) && (nd_q[0] == 2'h1);
  assign to_form = !save_q && (fld_q == 2'h2) && (nd_q[0] == 2'h0) &&
                   (nd_q[1] != 2'h0) && (nd_q[2] != 2'h0);
  // Only a closing brace ends a frame; anything malformed is dropped
  assign done = rx_valid && (st_q == P_ARG) && (rx_data == CH_CLOSE) &&
                !err_q && (en_form || to_form);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= P_IDLE;
      idx_q <= 3'h0;
      save_q <= 1'b0;
      err_q <= 1'b0;
      fld_q <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        acc_q[i] <= 7'h00;
        nd_q[i] <= 2'h0;
      end
    end else if (rx_valid) begin
      // An opening brace always restarts, even inside a frame
      if (rx_data == CH_OPEN) begin
        st_q <= P_HDR;
        idx_q <= 3'h0;
        save_q <= 1'b0;
        err_q <= 1'b0;
        fld_q <= 2'h0;
        for (int i = 0; i < 3; i++) begin
          acc_q[i] <= 7'h00;
          nd_q[i] <= 2'h0;
        end
      end else begin
        case (st_q)
          P_HDR: begin
            if (rx_data != hdr_char(idx_q, sv)) begin
              err_q <= 1'b1;
            end
            save_q <= sv;
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'h5) begin
              st_q <= P_ARG;
            end
          end
          P_ARG: begin
            if (rx_data == CH_CLOSE) begin
              st_q <= P_IDLE;
            end else if (rx_data == CH_COMMA && fld_q != 2'h2) begin
              fld_q <= fld_q + 2'h1;
            end else if (is_digit(rx_data) && nd_q[fld_q] != 2'h2) begin
              acc_q[fld_q] <= 7'(acc_q[fld_q] * 7'h0A + 7'(rx_data[3:0]));
              nd_q[fld_q] <= nd_q[fld_q] + 2'h1;
            end else begin
              err_q <= 1'b1;
            end
          end
          default: st_q <= P_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid <= 1'b0;
      cmd_kind <= K_EN;
      cmd_a <= 7'h00;
      cmd_b <= 7'h00;
    end else begin
      cmd_valid <= done;
      if (done) begin
        cmd_kind <= save_q ? K_SAVE : (to_form ? K_TOUT : K_EN);
        cmd_a <= to_form ? acc_q[1] : acc_q[0];
        cmd_b <= acc_q[2];
      end
    end
  end

  a_frame_close: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_valid |-> $past(rx_valid && rx_data == CH_CLOSE))
    else $error("command decoded without closing brace");
endmodule : iscl_cmd_parser

// ### verilog/iscl_top.sv
// Inactivity sleep controller: settings, idle timer, labels, replies, APB
//
// Summary of operation
// - After reset sleep is disabled; enable value 0 is off, 1 is on.
// - When enabled, sleep is entered after the configured idle time.
// - Timeout must lie between ten seconds and sixty minutes sixty seconds.
// - Timeout kept as minute and second fields, each 0 to 60; default 1 min.
// - Enable write answered with OK; timeout write answered by field echo.
// - Without save command or control register save, wake from sleep restores default settings.
// - Commands are framed by opening and closing curly braces only.
// - Label set: set label, two digit labels, same set label commits.
`timescale 1ns/1ps
module iscl_top
  import iscl_pkg::*;
#(
  parameter int unsigned SEC_CYC = SEC_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  input wire logic label_valid,
  input wire logic [7:0] label_code,
  input wire logic activity,
  input wire logic wake_req,
  output logic sleep,
  output logic sleep_en
);
  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_D1 = 2'b01,
    L_D2 = 2'b11,
    L_CMT = 2'b10
  } iscl_lst_e;

  logic en_q;
  logic [6:0] min_q;
  logic [6:0] sec_q;
  logic sv_en_q;
  logic [6:0] sv_min_q;
  logic [6:0] sv_sec_q;
  logic saved_q;
  logic err_q;
  logic sleep_q;
  logic [PRE_W-1:0] pre_q;
  logic [11:0] cnt_q;
  logic [11:0] tout;
  logic [127:0] rb_q;
  logic [4:0] rn_q;
  logic [127:0] msg;
  logic [4:0] mlen;
  logic [31:0] prdata_q;
  iscl_lst_e lab_st_q;
  logic lab_min_q;
  logic [6:0] lab_val_q;
  logic cmd_valid;
  iscl_kind_e cmd_kind;
  logic [6:0] cmd_a;
  logic [6:0] cmd_b;
  logic cmd_ok;
  logic apb_wr;
  logic ctrl_wr;
  logic tout_wr;
  logic mapped;
  logic wake;
  logic act;
  logic save_now;
  logic lab_set;
  logic lab_same;
  logic lab_commit;
  logic [6:0] wr_min;
  logic [6:0] wr_sec;

  iscl_cmd_parser u_parser (
    .pclk(pclk),
    .presetn(presetn),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind),
    .cmd_a(cmd_a),
    .cmd_b(cmd_b)
  );

  // APB slave: no wait states, read data captured in the setup cycle
  assign mapped = (paddr == CTRL_OFS) || (paddr == TOUT_OFS) ||
                  (paddr == STAT_OFS) || (paddr == IDLE_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;
  assign apb_wr = psel && penable && pwrite && mapped;
  assign ctrl_wr = apb_wr && (paddr == CTRL_OFS);
  assign wr_min = pwdata[6:0];
  assign wr_sec = pwdata[TOUT_SEC_LSB +: 7];
  // Out of span timeouts are refused whatever their source
  assign tout_wr = apb_wr && (paddr == TOUT_OFS) &&
                   (pwdata[7] == 1'b0) && (pwdata[TOUT_SEC_LSB+7] == 1'b0) &&
                   tout_ok(wr_min, wr_sec);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        CTRL_OFS: prdata_q <= 32'(en_q);
        TOUT_OFS: prdata_q <= 32'({sec_q, 1'b0, min_q});
        STAT_OFS: prdata_q <= 32'({err_q, saved_q, sleep_q});
        IDLE_OFS: prdata_q <= 32'(cnt_q);
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Host command acceptance
  always_comb begin
    case (cmd_kind)
      K_EN: cmd_ok = cmd_valid && (cmd_a <= 7'h01);
      K_TOUT: cmd_ok = cmd_valid && tout_ok(cmd_a, cmd_b);
      K_SAVE: cmd_ok = cmd_valid && (cmd_a == 7'h01);
      default: cmd_ok = 1'b0;
    endcase
  end

  assign wake = sleep_q && wake_req;
  assign save_now = (cmd_ok && cmd_kind == K_SAVE) ||
                    (ctrl_wr && pwdata[CTRL_SAVE_BIT]);

  // Scanned label sequence
  assign lab_set = (label_code == MINUTE_LABEL_CODE) ||
                   (label_code == SECOND_LABEL_CODE);
  assign lab_same = label_code ==
                    (lab_min_q ? MINUTE_LABEL_CODE : SECOND_LABEL_CODE);
  assign lab_commit = label_valid && (lab_st_q == L_CMT) && lab_same &&
                      tout_ok(lab_min_q ? lab_val_q : min_q,
                              lab_min_q ? sec_q : lab_val_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lab_st_q <= L_IDLE;
      lab_min_q <= 1'b0;
      lab_val_q <= 7'h00;
    end else if (label_valid) begin
      if (lab_set && !(lab_st_q == L_CMT && lab_same)) begin
        lab_st_q <= L_D1;
        lab_min_q <= (label_code == MINUTE_LABEL_CODE);
        lab_val_q <= 7'h00;
      end else begin
        case (lab_st_q)
          L_D1: begin
            lab_st_q <= is_digit(label_code) ? L_D2 : L_IDLE;
            lab_val_q <= 7'(label_code[3:0]);
          end
          L_D2: begin
            lab_st_q <= is_digit(label_code) ? L_CMT : L_IDLE;
            lab_val_q <= 7'(lab_val_q * 7'h0A + 7'(label_code[3:0]));
          end
          default: lab_st_q <= L_IDLE;
        endcase
      end
    end
  end

  // Settings: wake restore first, then APB, host command, label
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= DEF_EN;
      min_q <= DEF_MIN;
      sec_q <= DEF_SEC;
    end else if (wake) begin
      en_q <= saved_q ? sv_en_q : DEF_EN;
      min_q <= saved_q ? sv_min_q : DEF_MIN;
      sec_q <= saved_q ? sv_sec_q : DEF_SEC;
    end else if (ctrl_wr) begin
      en_q <= pwdata[CTRL_EN_BIT];
    end else if (tout_wr) begin
      min_q <= wr_min;
      sec_q <= wr_sec;
    end else if (cmd_ok && cmd_kind == K_EN) begin
      en_q <= cmd_a[0];
    end else if (cmd_ok && cmd_kind == K_TOUT) begin
      min_q <= cmd_a;
      sec_q <= cmd_b;
    end else if (lab_commit) begin
      en_q <= 1'b1;
      if (lab_min_q) begin
        min_q <= lab_val_q;
      end else begin
        sec_q <= lab_val_q;
      end
    end
  end

  // Persistent copy; a real part keeps it in flash across power loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sv_en_q <= DEF_EN;
      sv_min_q <= DEF_MIN;
      sv_sec_q <= DEF_SEC;
      saved_q <= 1'b0;
    end else if (save_now) begin
      sv_en_q <= en_q;
      sv_min_q <= min_q;
      sv_sec_q <= sec_q;
      saved_q <= 1'b1;
    end
  end

  // Rejected commands set a sticky flag; a new error wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (cmd_valid && !cmd_ok) begin
      err_q <= 1'b1;
    end else if (apb_wr && paddr == STAT_OFS && pwdata[STAT_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  // Idle timer counts whole seconds of inactivity
  assign act = activity || cmd_valid || label_valid;
  assign tout = tout_s(min_q, sec_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      cnt_q <= 12'h000;
    end else if (act || !en_q || sleep_q) begin
      pre_q <= '0;
      cnt_q <= 12'h000;
    end else if (pre_q == PRE_W'(SEC_CYC - 1)) begin
      pre_q <= '0;
      cnt_q <= (cnt_q < MAX_TOUT_S) ? cnt_q + 12'h001 : cnt_q;
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else if (wake) begin
      sleep_q <= 1'b0;
    end else if (en_q && !act && cnt_q >= tout) begin
      sleep_q <= 1'b1;
    end
  end

  assign sleep = sleep_q;
  assign sleep_en = en_q;

  // Reply text; fields echo the values just accepted
  always_comb begin
    msg = 128'h0;
    mlen = 5'h00;
    msg[47:0] = {CH_COMMA, CH_1, CH_1, CH_C, CH_M, CH_OPEN};
    if (cmd_kind == K_EN) begin
      msg[71:48] = {CH_CLOSE, CH_K, CH_O};
      mlen = 5'h09;
    end else begin
      msg[63:48] = {CH_COMMA, en_q ? CH_1 : CH_0};
      mlen = 5'h08;
      if (cmd_a >= 7'h0A) begin
        msg[8*mlen +: 8] = dec_tens(cmd_a);
        mlen = mlen + 5'h01;
      end
      msg[8*mlen +: 16] = {CH_COMMA, dec_ones(cmd_a)};
      mlen = mlen + 5'h02;
      if (cmd_b >= 7'h0A) begin
        msg[8*mlen +: 8] = dec_tens(cmd_b);
        mlen = mlen + 5'h01;
      end
      msg[8*mlen +: 16] = {CH_CLOSE, dec_ones(cmd_b)};
      mlen = mlen + 5'h02;
    end
  end

  // A new reply replaces one still being sent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_q <= 128'h0;
      rn_q <= 5'h00;
    end else if (cmd_ok && cmd_kind != K_SAVE) begin
      rb_q <= msg;
      rn_q <= mlen;
    end else if (tx_valid && tx_ready) begin
      rb_q <= rb_q >> 8;
      rn_q <= rn_q - 5'h01;
    end
  end

  assign tx_valid = (rn_q != 5'h00);
  assign tx_data = rb_q[7:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_enable_cause: assert property ($rose(en_q) |-> $past(ctrl_wr ||
    lab_commit || wake || (cmd_ok && cmd_kind == K_EN)))
    else $error("sleep enabled without a cause");
  a_sleep_entry: assert property ($rose(sleep_q) |->
    $past(en_q && cnt_q >= tout))
    else $error("sleep entered before timeout");
  a_tout_span: assert property (tout >= MIN_TOUT_S &&
    tout <= MAX_TOUT_S)
    else $error("timeout outside span");
  a_field_max: assert property (min_q <= MAX_FIELD &&
    sec_q <= MAX_FIELD)
    else $error("timeout field above 60");
  a_reply_start: assert property (cmd_ok && cmd_kind != K_SAVE |=>
    tx_valid && tx_data == CH_OPEN ##1 tx_valid)
    else $error("reply did not start");
  a_wake_default: assert property (wake && !saved_q |=> !en_q &&
    min_q == DEF_MIN && sec_q == DEF_SEC)
    else $error("defaults not restored on wake");
  a_save_copy: assert property (save_now |=> saved_q &&
    sv_min_q == $past(min_q) && sv_sec_q == $past(sec_q))
    else $error("settings not saved");
  a_label_order: assert property (lab_commit |-> $past(label_valid &&
    is_digit(label_code) && lab_st_q == L_D2))
    else $error("label commit out of order");
  a_idle_restart: assert property (act |=> cnt_q == 12'h000 &&
    pre_q == '0)
    else $error("idle count not restarted");

  c_cmd_tout: cover property (cmd_ok && cmd_kind == K_TOUT);
  c_label: cover property (lab_commit);
  c_sleep: cover property ($rose(sleep_q));
  c_wake_saved: cover property (wake && saved_q);
endmodule : iscl_top

// ### bench/iscl_host_model.sv
// Host side model: sends command bytes, collects reply bytes
`timescale 1ns/1ps
module iscl_host_model (
  input wire logic pclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic [7:0] rq[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Slow mode stalls every other cycle so replies must wait
  always @(posedge pclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      rq.push_back(tx_data);
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= s[i];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    // Released line must not keep showing the last byte
    rx_data <= ~rx_data;
  endtask : send
endmodule : iscl_host_model

// ### bench/iscl_top_tb.sv
// Self-checking bench for the inactivity sleep controller
`timescale 1ns/1ps
module iscl_top_tb;
  import iscl_pkg::*;
  // Short second so idle timeouts finish quickly
  localparam int unsigned SC = 4;
  typedef struct {
    string cmd;
    bit op;
    string rep;
    logic [31:0] tout;
    logic en;
  } iscl_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, rx_data, tx_data, label_code;
  logic [31:0] pwdata, prdata, rd;
  logic tx_valid, tx_ready, rx_valid, err, label_valid;
  logic activity, wake_req, sleep, sleep_en;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  // Command and reply tails; the header bytes come from the package
  iscl_row_s rows[8] = '{
    '{"1", 1'b1, "OK", 32'h0000_0001, 1'b1},
    '{",1,0", 1'b1, "1,1,0", 32'h0000_0001, 1'b1},
    '{"0", 1'b1, "OK", 32'h0000_0001, 1'b0},
    '{"1", 1'b0, "", 32'h0000_0001, 1'b0},
    '{",60,60", 1'b1, "0,60,60", 32'h0000_3C3C, 1'b0},
    '{",0,9", 1'b1, "", 32'h0000_3C3C, 1'b0},
    '{",61,0", 1'b1, "", 32'h0000_3C3C, 1'b0},
    '{",0,10", 1'b1, "0,0,10", 32'h0000_0A00, 1'b0}
  };
  iscl_top #(.SEC_CYC(SC)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .label_valid(label_valid), .label_code(label_code),
    .activity(activity), .wake_req(wake_req), .sleep(sleep),
    .sleep_en(sleep_en));
  iscl_host_model host (.pclk(pclk), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    check_count++;
    if (got !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : chk
  task automatic chk_rep(input string e);
    chk(32'(host.rq.size()), 32'(e.len()));
    for (int i = 0; i < e.len() && i < host.rq.size(); i++)
      chk({24'h0, host.rq[i]}, {24'h0, e[i]});
    host.rq.delete();
  endtask : chk_rep
  // Sleep configuration write, with or without its opening brace
  function automatic string wc(input string a, input bit op);
    string o;
    if (op) begin
      o = "{";
    end
    return $sformatf("%s%c%c%c%c%c%c%s}", o, CH_M, CH_C, CH_1, CH_1,
                     CH_W, CH_T, a);
  endfunction : wc
  // Expected sleep configuration reply; empty tail means no reply
  function automatic string rp(input string a);
    string r;
    if (a.len() != 0) begin
      r = $sformatf("{%c%c%c%c,%s}", CH_M, CH_C, CH_1, CH_1, a);
    end
    return r;
  endfunction : rp
  // Bus master: holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdreg(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdreg
  task automatic settle();
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 80 && tx_valid !== 1'b0; i++) @(posedge pclk);
    @(posedge pclk);
  endtask : settle
  task automatic lab(input logic [31:0] codes);
    for (int i = 3; i >= 0; i--) begin
      @(posedge pclk);
      label_valid <= 1'b1;
      label_code <= codes[8*i +: 8];
    end
    @(posedge pclk);
    label_valid <= 1'b0;
  endtask : lab
  task automatic kick();
    @(posedge pclk);
    activity <= 1'b1;
    @(posedge pclk);
    activity <= 1'b0;
  endtask : kick
  task automatic time_sleep();
    kick();
    n = 0;
    while (sleep !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
  endtask : time_sleep
  task automatic wake();
    @(posedge pclk);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    @(posedge pclk);
  endtask : wake
  initial begin
    {presetn, psel, penable, pwrite, label_valid} = 5'h00;
    {activity, wake_req} = 2'b00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    label_code = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({30'h0, sleep, sleep_en}, 32'h0000_0000);
    rdreg(CTRL_OFS, 32'h0000_0000);
    rdreg(TOUT_OFS, 32'h0000_0001);
    rdreg(8'h10, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    foreach (rows[i]) begin
      host.slow = i[0];
      host.send(wc(rows[i].cmd, rows[i].op));
      settle();
      chk_rep(rp(rows[i].rep));
      rdreg(TOUT_OFS, rows[i].tout);
      chk({31'h0, sleep_en}, {31'h0, rows[i].en});
    end
    rdreg(STAT_OFS, 32'h0000_0004);
    apb(1'b1, STAT_OFS, 32'h0000_0004);
    rdreg(STAT_OFS, 32'h0000_0000);
    host.send(wc("1", 1'b1));
    settle();
    chk_rep(rp("OK"));
    kick();
    repeat (30) @(posedge pclk);
    chk({31'h0, sleep}, 32'h0000_0000);
    // Seven whole seconds have elapsed since the kick
    rdreg(IDLE_OFS, 32'h0000_0007);
    time_sleep();
    // Ten seconds of four cycles, with slack for the prescaler phase
    chk(32'(n >= 36 && n <= 48), 32'h0000_0001);
    wake();
    chk({30'h0, sleep, sleep_en}, 32'h0000_0000);
    rdreg(TOUT_OFS, 32'h0000_0001);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    apb(1'b1, TOUT_OFS, 32'h0000_0A00);
    host.send($sformatf("{%c%c%c%c%c%c1}", CH_M, CH_C, CH_M, CH_D,
                        CH_W, CH_T));
    settle();
    chk_rep("");
    rdreg(STAT_OFS, 32'h0000_0002);
    time_sleep();
    chk({31'h0, sleep}, 32'h0000_0001);
    wake();
    chk({30'h0, sleep, sleep_en}, 32'h0000_0001);
    rdreg(TOUT_OFS, 32'h0000_0A00);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    lab(32'hB031_30B0);
    rdreg(TOUT_OFS, 32'h0000_0A0A);
    chk({31'h0, sleep_en}, 32'h0000_0001);
    lab(32'hB134_35B1);
    rdreg(TOUT_OFS, 32'h0000_2D0A);
    lab(32'hB037_30B0);
    rdreg(TOUT_OFS, 32'h0000_2D0A);
    // Save through the control register, then change the timeout again
    apb(1'b1, TOUT_OFS, 32'h0000_0B00);
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    apb(1'b1, TOUT_OFS, 32'h0000_0C00);
    time_sleep();
    chk({31'h0, sleep}, 32'h0000_0001);
    wake();
    rdreg(TOUT_OFS, 32'h0000_0B00);
    summarize();
  end
endmodule : iscl_top_tb
